// *** common/tcms_params.svh ***
`ifndef TCMS_PARAMS_SVH
`define TCMS_PARAMS_SVH

// Widths
`define TCMS_MV_W        12
`define TCMS_PV_W        16
`define TCMS_ERR_W       17

// Action setting encodings and command defaults
`define TCMS_ACT_REVERSE 1'b0
`define TCMS_ACT_DIRECT  1'b1
`define TCMS_CMD_DFLT    1'b0

// Output values in 0.1 % steps
`define TCMS_MV_OFF      12'h000
`define TCMS_ERR_MV_DFLT 12'h000
`define TCMS_MV_MAX      12'h41a
`define TCMS_MV_STD_MIN  12'hfce
`define TCMS_MV_HC_MIN   12'hbe6

`endif

// *** common/tcms_pkg.sv ***
package tcms_pkg;

   // Manual-output mode of the channel
   typedef enum logic [1:0]
   {
      TCMS_AUTO   = 2'b00,
      TCMS_HOLD   = 2'b01,
      TCMS_MANUAL = 2'b10
   } tcms_mode_e;

   typedef logic signed [11:0] tcms_mv_t;
   typedef logic signed [15:0] tcms_pv_t;
   typedef logic signed [16:0] tcms_err_t;

endpackage

// *** rtl/tcms_mv_select.sv ***
`timescale 1ns/1ps
`include "tcms_params.svh"
//
// Overview of operation
// [R1] Direct action: output rises with temperature
// [R2] Reverse action: output rises as temperature falls
// [R3] Action setting: 0 reverse, 1 direct, default 0
// [R4] Action setting change applies only after restart
// [R5] Inversion command swaps action immediately
// [R6] Command bits return to defaults at restart
// [R7] Status shows whether inversion is active
// [R8] Manual mode only under PID, via command
// [R9] Manual mode outputs reflected manual value
// [R10] Auto mode never outputs manual value
// [R11] Unreflected manual entry holds switching-time output
// [R12] Reflect set: adopt host manual value
// [R13] Manual after restart starts from manual value
// [R14] Manual to auto restarts PID bumplessly
// [R15] Auto mode ignores reflect bit
// [R16] Status shows mode and reflect state
// [R17] Manual value clamped to output limits
// [R18] Sensor break under PID outputs error value
// [R19] Load rejection value beats error value
// [R20] Error value 0.1 % steps, ranged, immediate
// [R21] Lower limit above upper uses upper
// [R22] Stopped control forces output off
// [R23] Effective action is setting XOR inversion
//
module tcms_mv_select
(
   // Clock, reset, enable
   input  wire logic                   i_sys_clk,
   input  wire logic                   i_resetn,
   input  wire logic                   i_ce,
   // Unit restart pulse and restart-time setting
   input  wire logic                   i_restart,
   input  wire logic                   i_cfg_direct,
   // Immediate settings
   input  wire logic                   i_pid_ctrl,
   input  wire logic                   i_heat_cool,
   input  wire tcms_pkg::tcms_mv_t     i_mv_upper,
   input  wire tcms_pkg::tcms_mv_t     i_mv_lower,
   input  wire tcms_pkg::tcms_mv_t     i_err_mv,
   input  wire logic                   i_lr_enable,
   input  wire tcms_pkg::tcms_mv_t     i_lr_mv,
   // Cyclic command word
   input  wire logic                   i_cmd_valid,
   input  wire logic                   i_cmd_run,
   input  wire logic                   i_cmd_invert,
   input  wire logic                   i_cmd_manual,
   input  wire logic                   i_cmd_reflect,
   input  wire tcms_pkg::tcms_mv_t     i_manual_mv,
   // Process and controller
   input  wire tcms_pkg::tcms_pv_t     i_pv,
   input  wire tcms_pkg::tcms_pv_t     i_sp,
   input  wire tcms_pkg::tcms_mv_t     i_pid_mv,
   input  wire logic                   i_sensor_fault,
   input  wire logic                   i_lr_active,
   // Controller steering
   output logic                        o_act_direct,
   output tcms_pkg::tcms_err_t         o_pid_err,
   output logic                        o_pid_preset,
   output tcms_pkg::tcms_mv_t          o_pid_preset_mv,
   // Output and status word
   output tcms_pkg::tcms_mv_t          o_mv,
   output logic                        o_sts_run,
   output logic                        o_sts_invert,
   output logic                        o_sts_manual,
   output logic                        o_sts_reflect
);

   logic                   rst_meta_r;
   logic                   rst_n_s;
   logic                   act_cfg_r;
   logic                   cap_done_r;
   logic                   cmd_run_r;
   logic                   cmd_inv_r;
   logic                   cmd_man_r;
   logic                   cmd_rfl_r;
   logic                   fresh_r;
   tcms_pkg::tcms_mode_e   mode_r;
   tcms_pkg::tcms_mode_e   mode_nxt;
   tcms_pkg::tcms_mv_t     hold_r;
   tcms_pkg::tcms_mv_t     mv_r;
   tcms_pkg::tcms_mv_t     mv_nxt;
   tcms_pkg::tcms_mv_t     lo_eff;
   tcms_pkg::tcms_mv_t     err_lim;
   tcms_pkg::tcms_mv_t     man_lim;
   tcms_pkg::tcms_mv_t     pid_lim;
   logic                   act_eff;
   logic                   preset_r;
   tcms_pkg::tcms_mv_t     preset_mv_r;
   tcms_pkg::tcms_err_t    pv_x;
   tcms_pkg::tcms_err_t    sp_x;

   // Clamp a value into [lo, hi]; lo already bounded by hi
   function automatic tcms_pkg::tcms_mv_t clamp_mv
   (
      input tcms_pkg::tcms_mv_t v,
      input tcms_pkg::tcms_mv_t lo,
      input tcms_pkg::tcms_mv_t hi
   );
      return (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction

   // Reset release through two flops
   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_meta_r <= 1'b0;
         rst_n_s    <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_s    <= rst_meta_r;
      end
   end

   // Action setting sampled only at reset release or restart
   always_ff @(posedge i_sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         act_cfg_r  <= `TCMS_ACT_REVERSE; // [R3]
         cap_done_r <= 1'b0;
      end
      else if (i_ce)
      begin
         if (!cap_done_r || i_restart)
         begin
            act_cfg_r  <= i_cfg_direct; // [R4]
            cap_done_r <= 1'b1;
         end
      end
   end

   // Command bits; restart puts them back to defaults
   always_ff @(posedge i_sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         cmd_run_r <= `TCMS_CMD_DFLT;
         cmd_inv_r <= `TCMS_CMD_DFLT;
         cmd_man_r <= `TCMS_CMD_DFLT;
         cmd_rfl_r <= `TCMS_CMD_DFLT;
      end
      else if (i_ce)
      begin
         if (i_restart)
         begin
            cmd_run_r <= `TCMS_CMD_DFLT; // [R6]
            cmd_inv_r <= `TCMS_CMD_DFLT; // [R6]
            cmd_man_r <= `TCMS_CMD_DFLT; // [R6]
            cmd_rfl_r <= `TCMS_CMD_DFLT; // [R6]
         end
         else if (i_cmd_valid)
         begin
            cmd_run_r <= i_cmd_run;
            cmd_inv_r <= i_cmd_invert;
            cmd_man_r <= i_cmd_manual;
            cmd_rfl_r <= i_cmd_reflect;
         end
      end
   end

   // Action steering of the controller error sign
   assign act_eff = act_cfg_r ^ cmd_inv_r; // [R23] [R5]
   assign pv_x    = tcms_pkg::tcms_err_t'(i_pv);
   assign sp_x    = tcms_pkg::tcms_err_t'(i_sp);

   assign o_pid_err = (act_eff == `TCMS_ACT_DIRECT) ? pv_x - sp_x  // [R1]
                                                   : sp_x - pv_x; // [R2]

   // Limits: inverted pair collapses onto the upper limit
   assign lo_eff  = (i_mv_lower > i_mv_upper) ? i_mv_upper : i_mv_lower; // [R21]
   assign man_lim = clamp_mv(i_manual_mv, lo_eff, i_mv_upper); // [R17]
   assign pid_lim = clamp_mv(i_pid_mv, lo_eff, i_mv_upper);
   // Out-of-range error value is pinned to the type's range, not rejected
   assign err_lim = clamp_mv(i_err_mv,
                             i_heat_cool ? `TCMS_MV_HC_MIN : `TCMS_MV_STD_MIN,
                             `TCMS_MV_MAX); // [R20]

   // Mode sequencing
   always_comb
   begin
      mode_nxt = mode_r;
      case (mode_r)
         tcms_pkg::TCMS_AUTO:
            // Reflect bit is not looked at while in auto
            if (cmd_man_r && i_pid_ctrl) // [R8] [R15]
               mode_nxt = tcms_pkg::TCMS_HOLD;
         tcms_pkg::TCMS_HOLD:
            if (!cmd_man_r || !i_pid_ctrl)
               mode_nxt = tcms_pkg::TCMS_AUTO;
            else if (cmd_rfl_r)
               mode_nxt = tcms_pkg::TCMS_MANUAL; // [R12]
         tcms_pkg::TCMS_MANUAL:
            if (!cmd_man_r || !i_pid_ctrl)
               mode_nxt = tcms_pkg::TCMS_AUTO;
            else if (!cmd_rfl_r)
               mode_nxt = tcms_pkg::TCMS_HOLD;
         default:
            mode_nxt = tcms_pkg::TCMS_AUTO;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         mode_r <= tcms_pkg::TCMS_AUTO;
      end
      else if (i_ce)
      begin
         mode_r <= i_restart ? tcms_pkg::TCMS_AUTO : mode_nxt;
      end
   end

   // Hold value taken on entering hold; an entry after restart before any run
   // in auto has no meaningful running output, so it starts from manual value
   always_ff @(posedge i_sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         hold_r  <= `TCMS_MV_OFF;
         fresh_r <= 1'b1;
      end
      else if (i_ce)
      begin
         if (i_restart)
         begin
            fresh_r <= 1'b1;
         end
         else
         begin
            if (mode_r != tcms_pkg::TCMS_HOLD && mode_nxt == tcms_pkg::TCMS_HOLD)
            begin
               hold_r <= fresh_r ? man_lim : mv_r; // [R13] [R11]
            end
            if (cmd_run_r && mode_r == tcms_pkg::TCMS_AUTO)
            begin
               fresh_r <= 1'b0;
            end
         end
      end
   end

   // Output priority: stop, load rejection, sensor error, manual, PID
   always_comb
   begin
      if (!cmd_run_r)
         mv_nxt = `TCMS_MV_OFF; // [R22]
      else if (i_lr_enable && i_lr_active)
         mv_nxt = i_lr_mv; // [R19]
      else if (i_pid_ctrl && i_sensor_fault)
         mv_nxt = err_lim; // [R18]
      else if (mode_r == tcms_pkg::TCMS_MANUAL)
         mv_nxt = man_lim; // [R9]
      else if (mode_r == tcms_pkg::TCMS_HOLD)
         mv_nxt = hold_r; // [R11]
      else
         mv_nxt = pid_lim; // [R10]
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         mv_r <= `TCMS_MV_OFF;
      end
      else if (i_ce)
      begin
         mv_r <= i_restart ? `TCMS_MV_OFF : mv_nxt;
      end
   end

   // Bumpless return: controller is preset with the last output
   always_ff @(posedge i_sys_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         preset_r    <= 1'b0;
         preset_mv_r <= `TCMS_MV_OFF;
      end
      else if (i_ce)
      begin
         preset_r <= 1'b0;
         if (!i_restart && mode_r != tcms_pkg::TCMS_AUTO &&
             mode_nxt == tcms_pkg::TCMS_AUTO)
         begin
            preset_r    <= 1'b1; // [R14]
            preset_mv_r <= mv_r; // [R14]
         end
      end
   end

   assign o_act_direct    = act_eff;
   assign o_pid_preset    = preset_r;
   assign o_pid_preset_mv = preset_mv_r;
   assign o_mv            = mv_r;
   assign o_sts_run       = cmd_run_r;
   assign o_sts_invert    = cmd_inv_r; // [R7]
   assign o_sts_manual    = (mode_r != tcms_pkg::TCMS_AUTO); // [R16]
   assign o_sts_reflect   = (mode_r == tcms_pkg::TCMS_MANUAL); // [R16]

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!rst_n_s);

   a_stop_forces_off: assert property ( // [R22]
      i_ce && !cmd_run_r |=> o_mv == `TCMS_MV_OFF)
      else $error("output not off while stopped");

   a_inv_immediate: assert property ( // [R5]
      i_ce && i_cmd_valid && !i_restart && i_cmd_invert != cmd_inv_r
      |=> o_act_direct != $past(o_act_direct))
      else $error("inversion did not swap action");

   a_cfg_needs_restart: assert property ( // [R4]
      cap_done_r && !i_restart
      |=> o_act_direct == ($past(o_act_direct) ^ o_sts_invert ^ $past(o_sts_invert)))
      else $error("action changed without restart");

   a_restart_defaults: assert property ( // [R6]
      i_ce && i_restart |=> !o_sts_run && !o_sts_invert && !o_sts_manual)
      else $error("commands not defaulted at restart");

   a_lr_priority: assert property ( // [R19]
      i_ce && cmd_run_r && !i_restart && i_lr_enable && i_lr_active
      |=> o_mv == $past(i_lr_mv))
      else $error("load rejection value not output");

   a_sensor_err_out: assert property ( // [R18]
      i_ce && cmd_run_r && !i_restart && !(i_lr_enable && i_lr_active)
      && i_pid_ctrl && i_sensor_fault |=> o_mv == $past(err_lim))
      else $error("error value not output on sensor break");

   a_manual_clamped: assert property ( // [R17]
      i_ce && !i_restart && cmd_run_r && o_sts_reflect
      && !(i_lr_enable && i_lr_active) && !(i_pid_ctrl && i_sensor_fault)
      |=> o_mv <= $past(i_mv_upper) && o_mv >= $past(lo_eff))
      else $error("manual value outside output limits");

   a_hold_stable: assert property ( // [R11]
      i_ce && mode_r == tcms_pkg::TCMS_HOLD && mode_nxt == tcms_pkg::TCMS_HOLD
      && cmd_run_r && !i_sensor_fault && !i_lr_active && !i_restart
      |=> o_mv == hold_r && $stable(hold_r))
      else $error("held output moved");

   a_auto_ignores_rfl: assert property ( // [R15]
      i_ce && !i_restart && mode_r == tcms_pkg::TCMS_AUTO && cmd_rfl_r |=> !o_sts_reflect)
      else $error("reflect seen in auto");

   a_preset_value: assert property ( // [R14]
      o_pid_preset |-> o_pid_preset_mv == $past(o_mv) && !o_sts_manual)
      else $error("preset not from last output");

   c_manual_reflect: cover property (
      o_sts_manual && !o_sts_reflect ##[1:20] o_sts_reflect);
   c_bumpless_back: cover property (o_sts_reflect ##[1:20] o_pid_preset);
   c_lr_over_error: cover property (cmd_run_r && i_sensor_fault && i_lr_active);

endmodule

// *** testbench/control_output_mv_selector_bench.sv ***
`timescale 1ns/1ps
module control_output_mv_selector_bench;
   logic clk, rstn, restart, cfg_dir, pid, hc, lr_en, lr_act, fault, cv, run, inv, man, refl;
   logic act, pre, s_run, s_inv, s_man, s_refl, seen, ce;
   tcms_pkg::tcms_mv_t upper, lower, err_mv, lr_mv, man_mv, pid_mv, mv, pre_mv, pmv;
   tcms_pkg::tcms_pv_t pv, sp;
   tcms_pkg::tcms_err_t perr;
   int failures, samples_checked;

   tcms_mv_select i_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_restart(restart),
      .i_cfg_direct(cfg_dir), .i_pid_ctrl(pid), .i_heat_cool(hc), .i_mv_upper(upper),
      .i_mv_lower(lower), .i_err_mv(err_mv), .i_lr_enable(lr_en), .i_lr_mv(lr_mv),
      .i_cmd_valid(cv), .i_cmd_run(run), .i_cmd_invert(inv), .i_cmd_manual(man),
      .i_cmd_reflect(refl), .i_manual_mv(man_mv), .i_pv(pv), .i_sp(sp), .i_pid_mv(pid_mv),
      .i_sensor_fault(fault), .i_lr_active(lr_act), .o_act_direct(act), .o_pid_err(perr),
      .o_pid_preset(pre), .o_pid_preset_mv(pre_mv), .o_mv(mv), .o_sts_run(s_run),
      .o_sts_invert(s_inv), .o_sts_manual(s_man), .o_sts_reflect(s_refl));

   tcms_host_model i_host (.i_sys_clk(clk), .i_mv_mon(mv), .o_cmd_valid(cv), .o_cmd_run(run),
      .o_cmd_invert(inv), .o_cmd_manual(man), .o_cmd_reflect(refl), .o_manual_mv(man_mv));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic signed [16:0] got, input logic signed [16:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %0d expected %0d", $time, got, exp);
      end
   endtask

   task automatic wait_cy(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic do_restart();
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      wait_cy(4);
   endtask

   task automatic t_action();
      chk(act, 0);
      chk(perr, 17'sd20);
      cfg_dir <= 1'b1;
      wait_cy(4);
      chk(act, 0);
      do_restart();
      chk(act, 1);
      chk(perr, -17'sd20);
      i_host.send(1'b0, 1'b1, 1'b0, 1'b0);
      chk(act, 0);
      chk(s_inv, 1);
      chk(perr, 17'sd20);
      do_restart();
      chk(s_inv, 0);
      chk(act, 1);
   endtask

   task automatic t_manual();
      i_host.send(1'b1, 1'b0, 1'b0, 1'b1);
      chk(mv, 300);
      chk(s_refl, 0);
      i_host.send(1'b1, 1'b0, 1'b1, 1'b0);
      pid_mv <= 12'h1f4;
      wait_cy(3);
      chk(s_man, 1);
      chk(mv, 300);
      i_host.reflect_bumpless();
      chk(s_refl, 1);
      chk(mv, 300);
      i_host.set_manual(12'h190);
      wait_cy(3);
      chk(mv, 400);
      i_host.set_manual(12'h4b0);
      wait_cy(3);
      chk(mv, 1000);
      i_host.set_manual(12'h15e);
      wait_cy(3);
      seen = 1'b0;
      fork
         i_host.send(1'b1, 1'b0, 1'b0, 1'b0);
         repeat (5)
         begin
            @(posedge clk);
            #1;
            if (pre === 1'b1)
            begin
               seen = 1'b1;
               pmv = pre_mv;
            end
         end
      join
      chk(seen, 1);
      chk(pmv, 350);
      chk(mv, 500);
      chk(s_man, 0);
   endtask

   task automatic t_priority();
      pid <= 1'b0;
      i_host.send(1'b1, 1'b0, 1'b1, 1'b0);
      chk(s_man, 0);
      i_host.send(1'b1, 1'b0, 1'b0, 1'b0);
      pid <= 1'b1;
      fault <= 1'b1;
      upper <= 12'h41a;
      lower <= 12'hfce;
      err_mv <= 12'h44c;
      wait_cy(3);
      chk(mv, 1050);
      err_mv <= 12'h800;
      wait_cy(3);
      chk(mv, -50);
      hc <= 1'b1;
      wait_cy(3);
      chk(mv, -1050);
      hc <= 1'b0;
      err_mv <= 12'h064;
      wait_cy(3);
      chk(mv, 100);
      lr_en <= 1'b1;
      lr_act <= 1'b1;
      wait_cy(3);
      chk(mv, 77);
      lr_en <= 1'b0;
      fault <= 1'b0;
      upper <= 12'h0c8;
      lower <= 12'h190;
      pid_mv <= 12'h064;
      wait_cy(3);
      chk(mv, 200);
      upper <= 12'h3e8;
      lower <= 12'h000;
      i_host.send(1'b0, 1'b0, 1'b0, 1'b0);
      chk(mv, 0);
      chk(s_run, 0);
   endtask

   // Command offered while frozen must be lost
   task automatic t_freeze();
      ce <= 1'b0;
      i_host.send(1'b1, 1'b1, 1'b0, 1'b0);
      chk(s_run, 0);
      chk(s_inv, 0);
      chk(mv, 0);
      ce <= 1'b1;
   endtask

   task automatic t_power_restore();
      i_host.send(1'b1, 1'b0, 1'b1, 1'b1);
      i_host.set_manual(12'h1c2);
      do_restart();
      chk(s_man, 0);
      chk(mv, 0);
      i_host.send(1'b1, 1'b0, 1'b1, 1'b0);
      wait_cy(2);
      chk(mv, 450);
   endtask

   task automatic conclude();
      if (failures == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      failures = 0;
      samples_checked = 0;
      rstn = 1'b0;
      ce = 1'b1;
      restart = 1'b0;
      cfg_dir = 1'b0;
      pid = 1'b1;
      hc = 1'b0;
      upper = 12'h3e8;
      lower = 12'h000;
      err_mv = 12'h000;
      lr_en = 1'b0;
      lr_mv = 12'h04d;
      lr_act = 1'b0;
      fault = 1'b0;
      pid_mv = 12'h12c;
      pv = 16'sd250;
      sp = 16'sd270;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      wait_cy(5);
      t_action();
      t_manual();
      t_priority();
      t_freeze();
      t_power_restore();
      conclude();
   end

   // Whole run needs well under 1000 cycles
   initial
   begin
      #20000;
      failures++;
      conclude();
   end
endmodule

// *** testbench/tcms_host_model.sv ***
`timescale 1ns/1ps
module tcms_host_model
(
   // Clock
   input  wire logic               i_sys_clk,
   // Monitored output
   input  wire tcms_pkg::tcms_mv_t i_mv_mon,
   // Command word
   output logic                    o_cmd_valid,
   output logic                    o_cmd_run,
   output logic                    o_cmd_invert,
   output logic                    o_cmd_manual,
   output logic                    o_cmd_reflect,
   output tcms_pkg::tcms_mv_t      o_manual_mv
);
   initial
   begin
      o_cmd_valid   = 1'b0;
      o_cmd_run     = 1'b0;
      o_cmd_invert  = 1'b0;
      o_cmd_manual  = 1'b0;
      o_cmd_reflect = 1'b0;
      o_manual_mv   = 12'h000;
   end

   // Valid is dropped a cycle later so each word is taken once
   task automatic send(input logic r, input logic i, input logic m, input logic f);
      @(posedge i_sys_clk);
      o_cmd_valid   <= 1'b1;
      o_cmd_run     <= r;
      o_cmd_invert  <= i;
      o_cmd_manual  <= m;
      o_cmd_reflect <= f;
      @(posedge i_sys_clk);
      o_cmd_valid   <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      #1;
   endtask

   task automatic set_manual(input tcms_pkg::tcms_mv_t v);
      @(posedge i_sys_clk);
      o_manual_mv <= v;
   endtask

   // Copy monitored output before reflecting, so the handover is bumpless
   task automatic reflect_bumpless();
      set_manual(i_mv_mon);
      send(1'b1, 1'b0, 1'b1, 1'b1);
   endtask
endmodule
